// [logic/cie_exec.sv]
// Decode and execute of the compact 16-bit instruction group
//
// How it works
// - Paired move writes two registers; destinations from eight-entry pair table; no exception.
// - Paired move source codes decode to registers 0, 2, 3, 16 to 20.
// - Invert: group 010001, minor 0000; target gets complement of source.
// - OR: minor 1001; target gets source OR target.
// - Invert, OR and shift register codes decode to registers 2 to 7, 16, 17.
// - Byte store: opcode 100010, data, base, 4-bit offset; stores low byte.
// - Store data code maps to 0, 2-7, 17; base to 2-7, 16, 17.
// - Byte store may raise translation, bus, address and watch exceptions.
// - Breakpoint raises debug breakpoint, or debug-mode breakpoint when in debug mode.
// - Breakpoint inside debug mode sets debug cause field to 0x9.
// - Breakpoint code field has no hardware effect.
// - Halfword store writes low 16 bits at base plus offset shifted by one.
// - Before revision 6 an odd halfword address raises address error.
// - Left shift fills vacated low bits with zeros.
// - Right shift fills vacated high bits with zeros.
// - Shift code 0 means 8; codes 1 to 7 shift by their value.
`timescale 1ns/1ps
`include "cie_map.svh"

module cie_exec #(
    parameter bit REV6_MISALIGN = 1'b0
) (
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    input  wire logic        instr_valid_i,
    input  wire logic [15:0] instr_i,
    input  wire logic        debug_mode_flag_i,
    output logic [4:0]       rd_addr_a_o,
    output logic [4:0]       rd_addr_b_o,
    input  wire logic [31:0] rd_data_a_i,
    input  wire logic [31:0] rd_data_b_i,
    output logic             wr_en_a_o,
    output logic [4:0]       wr_addr_a_o,
    output logic [31:0]      wr_data_a_o,
    output logic             wr_en_b_o,
    output logic [4:0]       wr_addr_b_o,
    output logic [31:0]      wr_data_b_o,
    output logic             st_req_o,
    output logic [31:0]      st_addr_o,
    output logic [31:0]      st_data_o,
    output logic [3:0]       st_byte_en_o,
    output logic             st_half_o,
    input  wire logic        st_exc_i,
    output logic             st_exc_o,
    output logic             exc_valid_o,
    output cie_pkg::cie_exc_t exc_kind_o,
    output logic             debug_cause_we_o,
    output logic [4:0]       debug_cause_field_o,
    output logic             busy_o
);

    // ****************************************
    // Register code maps
    // ****************************************
    function automatic logic [4:0] map_pair_src(input logic [2:0] c);
        logic [4:0] r;
        r = 5'h00;
        case (c)
            3'h0:    r = 5'h00;
            3'h1:    r = 5'h11;
            3'h2:    r = 5'h02;
            3'h3:    r = 5'h03;
            3'h4:    r = 5'h10;
            3'h5:    r = 5'h12;
            3'h6:    r = 5'h13;
            default: r = 5'h14;
        endcase
        return r;
    endfunction

    // Codes 0..5 are registers 16,17,2..5; 6,7 are 6,7
    function automatic logic [4:0] map_alu(input logic [2:0] c);
        logic [4:0] r;
        r = 5'h00;
        case (c)
            3'h0:    r = 5'h10;
            3'h1:    r = 5'h11;
            default: r = {2'b00, c};
        endcase
        return r;
    endfunction

    function automatic logic [4:0] map_store_data(input logic [2:0] c);
        logic [4:0] r;
        r = 5'h00;
        case (c)
            3'h0:    r = 5'h00;
            3'h1:    r = 5'h11;
            default: r = {2'b00, c};
        endcase
        return r;
    endfunction

    function automatic logic [9:0] map_pair_dst(input logic [2:0] c);
        logic [9:0] r;
        r = 10'h000;
        case (c)
            3'h0:    r = {5'h05, 5'h06};
            3'h1:    r = {5'h05, 5'h07};
            3'h2:    r = {5'h06, 5'h07};
            3'h3:    r = {5'h04, 5'h15};
            3'h4:    r = {5'h04, 5'h16};
            3'h5:    r = {5'h04, 5'h05};
            3'h6:    r = {5'h04, 5'h06};
            default: r = {5'h04, 5'h07};
        endcase
        return r;
    endfunction

    // ****************************************
    // Instruction fields
    // ****************************************
    // The first source code straddles bit 2, which marks the paired move
    logic [2:0] first_source_code;
    logic [2:0] second_source_code;

    assign first_source_code  = {instr_i[1:0], instr_i[3]};
    assign second_source_code = instr_i[6:4];

    // ****************************************
    // Decode stage
    // ****************************************
    cie_pkg::cie_kind_t kind_d;
    logic [5:0]         op;
    logic [3:0]         minor;

    assign op    = instr_i[`CIE_OP_HI:`CIE_OP_LO];
    assign minor = instr_i[3:0];

    always_comb begin
        kind_d = cie_pkg::CIE_NONE;
        if (instr_valid_i) begin
            case (op)
                `CIE_OP_GROUP_C: begin
                    // Bit 3 is a source bit, so only bit 2 may mark the paired move
                    if (instr_i[2] == 1'b1)
                        kind_d = cie_pkg::CIE_MOVE_PAIR;
                    else if (minor == `CIE_MIN_INVERT)
                        kind_d = cie_pkg::CIE_INVERT;
                    else if (minor == `CIE_MIN_OR)
                        kind_d = cie_pkg::CIE_OR;
                    else if (minor == `CIE_MIN_BREAK)
                        kind_d = cie_pkg::CIE_BREAK;
                end
                `CIE_OP_BYTE_ST: kind_d = cie_pkg::CIE_BYTE_ST;
                `CIE_OP_HALF_ST: kind_d = cie_pkg::CIE_HALF_ST;
                `CIE_OP_LSHIFT:  kind_d = cie_pkg::CIE_SHIFT;
                `CIE_OP_RSHIFT:  kind_d = cie_pkg::CIE_SHIFT;
                default:         kind_d = cie_pkg::CIE_NONE;
            endcase
        end
    end

    // Read ports address mux, registered to align with the file's read data
    logic [4:0] ra_d;
    logic [4:0] rb_d;

    always_comb begin
        ra_d = 5'h00;
        rb_d = 5'h00;
        case (kind_d)
            cie_pkg::CIE_MOVE_PAIR: begin
                ra_d = map_pair_src(first_source_code);
                rb_d = map_pair_src(second_source_code);
            end
            cie_pkg::CIE_INVERT, cie_pkg::CIE_OR: begin
                ra_d = map_alu(instr_i[6:4]);
                rb_d = map_alu(instr_i[9:7]);
            end
            cie_pkg::CIE_BYTE_ST, cie_pkg::CIE_HALF_ST: begin
                ra_d = map_alu(instr_i[6:4]);
                rb_d = map_store_data(instr_i[9:7]);
            end
            cie_pkg::CIE_SHIFT: begin
                ra_d = map_alu(instr_i[6:4]);
                rb_d = 5'h00;
            end
            default: begin
                ra_d = 5'h00;
                rb_d = 5'h00;
            end
        endcase
    end

    // ****************************************
    // Operand fetch stage
    // ****************************************
    cie_pkg::cie_kind_t kind_q;
    logic [15:0]        instr_q;
    logic               dm_q;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            kind_q      <= cie_pkg::CIE_NONE;
            instr_q     <= 16'h0000;
            dm_q        <= 1'b0;
            rd_addr_a_o <= 5'h00;
            rd_addr_b_o <= 5'h00;
        end else begin
            kind_q      <= kind_d;
            instr_q     <= instr_i;
            dm_q        <= debug_mode_flag_i;
            rd_addr_a_o <= ra_d;
            rd_addr_b_o <= rb_d;
        end
    end

    // ****************************************
    // Execute stage
    // ****************************************
    logic [5:0]  shamt;
    logic [31:0] st_addr;
    logic [3:0]  off4;
    logic        half_bad;
    logic [2:0]  shift_amount_code;
    logic [2:0]  dest_code;

    assign off4  = instr_q[3:0];
    assign shift_amount_code = instr_q[3:1];
    assign dest_code         = instr_q[9:7];
    // Code 0 would be a no-op shift, so it is reused for 8
    assign shamt = (shift_amount_code == 3'h0) ? `CIE_SHIFT_ZERO_AS
                 : {3'b000, shift_amount_code};
    assign st_addr = (kind_q == cie_pkg::CIE_HALF_ST)
                   ? rd_data_a_i + {27'h0, off4, 1'b0}
                   : rd_data_a_i + {28'h0, off4};
    assign half_bad = (kind_q == cie_pkg::CIE_HALF_ST) && st_addr[0] && !REV6_MISALIGN;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            wr_en_a_o   <= 1'b0;
            wr_addr_a_o <= 5'h00;
            wr_data_a_o <= 32'h0000_0000;
            wr_en_b_o   <= 1'b0;
            wr_addr_b_o <= 5'h00;
            wr_data_b_o <= 32'h0000_0000;
        end else begin
            wr_en_a_o <= 1'b0;
            wr_en_b_o <= 1'b0;
            case (kind_q)
                cie_pkg::CIE_MOVE_PAIR: begin
                    {wr_addr_a_o, wr_addr_b_o} <= map_pair_dst(dest_code);
                    wr_data_a_o <= rd_data_a_i;
                    wr_data_b_o <= rd_data_b_i;
                    wr_en_a_o   <= 1'b1;
                    wr_en_b_o   <= 1'b1;
                end
                cie_pkg::CIE_INVERT: begin
                    wr_addr_a_o <= map_alu(instr_q[9:7]);
                    wr_data_a_o <= ~rd_data_a_i;
                    wr_en_a_o   <= 1'b1;
                end
                cie_pkg::CIE_OR: begin
                    wr_addr_a_o <= map_alu(instr_q[9:7]);
                    wr_data_a_o <= rd_data_a_i | rd_data_b_i;
                    wr_en_a_o   <= 1'b1;
                end
                cie_pkg::CIE_SHIFT: begin
                    wr_addr_a_o <= map_alu(instr_q[9:7]);
                    if (instr_q[15:10] == `CIE_OP_LSHIFT)
                        wr_data_a_o <= rd_data_a_i << shamt;
                    else
                        wr_data_a_o <= rd_data_a_i >> shamt;
                    wr_en_a_o   <= 1'b1;
                end
                default: begin
                    wr_en_a_o <= 1'b0;
                    wr_en_b_o <= 1'b0;
                end
            endcase
        end
    end

    // Stores go to the load/store unit, which reports its own faults
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            st_req_o     <= 1'b0;
            st_addr_o    <= 32'h0000_0000;
            st_data_o    <= 32'h0000_0000;
            st_byte_en_o <= 4'h0;
            st_half_o    <= 1'b0;
        end else begin
            st_req_o <= 1'b0;
            if ((kind_q == cie_pkg::CIE_BYTE_ST || kind_q == cie_pkg::CIE_HALF_ST)
                && !half_bad) begin
                st_req_o  <= 1'b1;
                st_addr_o <= st_addr;
                st_half_o <= (kind_q == cie_pkg::CIE_HALF_ST);
                if (kind_q == cie_pkg::CIE_HALF_ST) begin
                    st_data_o    <= {16'h0000, rd_data_b_i[15:0]};
                    st_byte_en_o <= 4'h3;
                end else begin
                    st_data_o    <= {24'h000000, rd_data_b_i[7:0]};
                    st_byte_en_o <= 4'h1;
                end
            end
        end
    end

    // ****************************************
    // Exceptions and debug cause
    // ****************************************
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            exc_valid_o         <= 1'b0;
            exc_kind_o          <= cie_pkg::CIE_EXC_NONE;
            debug_cause_we_o    <= 1'b0;
            debug_cause_field_o <= 5'h00;
            st_exc_o            <= 1'b0;
        end else begin
            exc_valid_o      <= 1'b0;
            exc_kind_o       <= cie_pkg::CIE_EXC_NONE;
            debug_cause_we_o <= 1'b0;
            st_exc_o         <= st_exc_i;
            if (kind_q == cie_pkg::CIE_BREAK) begin
                exc_valid_o <= 1'b1;
                if (!dm_q) begin
                    exc_kind_o <= cie_pkg::CIE_EXC_DEBUG_BP;
                end else begin
                    exc_kind_o          <= cie_pkg::CIE_EXC_DEBUG_MODE_BP;
                    debug_cause_we_o    <= 1'b1;
                    debug_cause_field_o <= `CIE_DEBUG_CAUSE_BP;
                end
            end else if (half_bad) begin
                exc_valid_o <= 1'b1;
                exc_kind_o  <= cie_pkg::CIE_EXC_ADDR_ERR;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i)
            busy_o <= 1'b0;
        else
            busy_o <= (kind_d != cie_pkg::CIE_NONE);
    end

endmodule

// [logic/cie_map.svh]
// Encodings, field positions and fixed values of the compact instruction executor
`ifndef CIE_MAP_SVH
`define CIE_MAP_SVH

`define CIE_OP_HI         15
`define CIE_OP_LO         10
`define CIE_OP_GROUP_C    6'h11
`define CIE_OP_BYTE_ST    6'h22
`define CIE_OP_HALF_ST    6'h2a
`define CIE_OP_LSHIFT     6'h09
`define CIE_OP_RSHIFT     6'h19
`define CIE_MIN_INVERT    4'h0
`define CIE_MIN_OR        4'h9
`define CIE_MIN_BREAK     4'hb
`define CIE_DEBUG_CAUSE_BP 5'h09
`define CIE_SHIFT_ZERO_AS 6'h08

`endif

// [logic/cie_pkg.sv]
// Types shared by the compact instruction executor
package cie_pkg;
    typedef enum logic [2:0] {
        CIE_NONE,
        CIE_MOVE_PAIR,
        CIE_INVERT,
        CIE_OR,
        CIE_BYTE_ST,
        CIE_HALF_ST,
        CIE_BREAK,
        CIE_SHIFT
    } cie_kind_t;

    typedef enum logic [1:0] {
        CIE_EXC_NONE,
        CIE_EXC_DEBUG_BP,
        CIE_EXC_DEBUG_MODE_BP,
        CIE_EXC_ADDR_ERR
    } cie_exc_t;
endpackage

// [test/cie_exec_sva.sv]
// Port checks for the compact instruction executor
`timescale 1ns/1ps
`include "cie_map.svh"
module cie_exec_sva #(
    parameter bit REV6_MISALIGN = 1'b0
) (
    input wire logic              mclk_i,
    input wire logic              reset_i,
    input wire logic              instr_valid_i,
    input wire logic [15:0]       instr_i,
    input wire logic              debug_mode_flag_i,
    input wire logic              wr_en_a_o,
    input wire logic              wr_en_b_o,
    input wire logic              st_req_o,
    input wire logic [31:0]       st_addr_o,
    input wire logic [3:0]        st_byte_en_o,
    input wire logic              st_half_o,
    input wire logic              st_exc_i,
    input wire logic              st_exc_o,
    input wire logic              exc_valid_o,
    input wire cie_pkg::cie_exc_t exc_kind_o,
    input wire logic              debug_cause_we_o,
    input wire logic [4:0]        debug_cause_field_o,
    input wire logic              busy_o
);
    logic [5:0] op;
    logic       grp;
    logic       brk;
    logic       rop;
    logic       known;
    // Invalid cycles map to an unused opcode so nothing decodes
    assign op    = instr_valid_i ? instr_i[15:10] : 6'h00;
    assign grp   = op == `CIE_OP_GROUP_C;
    assign brk   = grp && instr_i[3:0] == `CIE_MIN_BREAK;
    assign rop   = grp && (instr_i[3:0] == `CIE_MIN_INVERT || instr_i[3:0] == `CIE_MIN_OR)
                   || op == `CIE_OP_LSHIFT || op == `CIE_OP_RSHIFT;
    assign known = rop || brk || grp && instr_i[2]
                   || op == `CIE_OP_BYTE_ST || op == `CIE_OP_HALF_ST;

    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    brk_plain_a: assert property (
        brk && !debug_mode_flag_i |-> ##2 exc_valid_o && exc_kind_o == cie_pkg::CIE_EXC_DEBUG_BP)
        else $error("breakpoint kind wrong outside debug mode");
    brk_dm_a: assert property (
        brk && debug_mode_flag_i |-> ##2 exc_valid_o && debug_cause_we_o
        && exc_kind_o == cie_pkg::CIE_EXC_DEBUG_MODE_BP && debug_cause_field_o == 5'h09)
        else $error("breakpoint in debug mode misreported");
    reg_quiet_a: assert property (
        rop |-> ##2 $onehot({wr_en_a_o, wr_en_b_o}) && !exc_valid_o && !st_req_o)
        else $error("register op wrote wrongly or raised something");
    pair_wr_a: assert property (
        grp && instr_i[2] |-> ##2 wr_en_a_o && wr_en_b_o && !exc_valid_o)
        else $error("paired move did not write both registers");
    byte_st_a: assert property (
        op == `CIE_OP_BYTE_ST |-> ##2 st_req_o && !st_half_o && st_byte_en_o == 4'h1)
        else $error("byte store request wrong");
    half_st_a: assert property (
        op == `CIE_OP_HALF_ST |-> ##2 st_req_o && st_half_o && st_byte_en_o == 4'h3
        || exc_valid_o && exc_kind_o == cie_pkg::CIE_EXC_ADDR_ERR && !st_req_o)
        else $error("halfword store neither stored nor faulted");
    half_align_a: assert property (
        st_req_o && st_half_o |-> REV6_MISALIGN || !st_addr_o[0])
        else $error("odd halfword address stored");
    exc_relay_a: assert property (
        st_exc_i |=> st_exc_o)
        else $error("store unit exception not passed on");
    unknown_a: assert property (
        !known |-> ##2 !(wr_en_a_o || wr_en_b_o || st_req_o || exc_valid_o))
        else $error("unknown word had an effect");
    busy_flag_a: assert property (
        busy_o == $past(known))
        else $error("busy does not follow the recognised word");
endmodule

bind cie_exec cie_exec_sva #(.REV6_MISALIGN(REV6_MISALIGN)) u_sva (.*);

// [test/cie_gpr_model.sv]
// Register file model behind the executor's read and write ports
`timescale 1ns/1ps
module cie_gpr_model (
    input  wire logic        mclk_i,
    input  wire logic [4:0]  ra_i,
    input  wire logic [4:0]  rb_i,
    output logic      [31:0] da_o,
    output logic      [31:0] db_o,
    input  wire logic        wea_i,
    input  wire logic [4:0]  wa_i,
    input  wire logic [31:0] wda_i,
    input  wire logic        web_i,
    input  wire logic [4:0]  wb_i,
    input  wire logic [31:0] wdb_i
);
    logic [31:0] gpr_q [32];
    // Even registers except 0 hold odd values, so base parity is known
    initial begin
        for (int i = 0; i < 32; i++) begin
            gpr_q[i] = (i == 0) ? 32'h0 : 32'h8421_0f0f ^ (i * 32'h0107_0301);
        end
    end
    assign da_o = gpr_q[ra_i];
    assign db_o = gpr_q[rb_i];
    always @(posedge mclk_i) begin
        if (wea_i && wa_i != 5'h00) gpr_q[wa_i] <= wda_i;
        if (web_i && wb_i != 5'h00) gpr_q[wb_i] <= wdb_i;
    end
endmodule

// [test/compact_16bit_instr_exec_tb.sv]
// Self-checking bench for the compact instruction executor
`timescale 1ns/1ps
module compact_16bit_instr_exec_tb;
    logic              mclk_i = 1'b0;
    logic              reset_i = 1'b1;
    logic              instr_valid_i = 1'b0;
    logic [15:0]       instr_i = 16'h0000;
    logic              debug_mode_flag_i = 1'b0;
    logic              st_exc_i = 1'b0;
    logic [4:0]        rd_addr_a_o, rd_addr_b_o, wr_addr_a_o, wr_addr_b_o, debug_cause_field_o;
    logic [31:0]       rd_data_a_i, rd_data_b_i, wr_data_a_o, wr_data_b_o, st_addr_o, st_data_o;
    logic              wr_en_a_o, wr_en_b_o, st_req_o, st_half_o, st_exc_o, exc_valid_o;
    logic              debug_cause_we_o, busy_o;
    logic [3:0]        st_byte_en_o;
    cie_pkg::cie_exc_t exc_kind_o;
    int                err_count = 0;
    int                n_checks = 0;
    int                cyc = 0;

    initial begin
        forever #12.5 mclk_i = ~mclk_i;
    end

    cie_exec uut (.*);
    cie_gpr_model pm (.mclk_i, .ra_i(rd_addr_a_o), .rb_i(rd_addr_b_o), .da_o(rd_data_a_i),
        .db_o(rd_data_b_i), .wea_i(wr_en_a_o), .wa_i(wr_addr_a_o), .wda_i(wr_data_a_o),
        .web_i(wr_en_b_o), .wb_i(wr_addr_b_o), .wdb_i(wr_data_b_o));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One word, then wait until its results stand two edges later
    task automatic op(input logic [15:0] w, input logic dm);
        @(posedge mclk_i) #1;
        instr_i = w;
        instr_valid_i = 1'b1;
        debug_mode_flag_i = dm;
        @(posedge mclk_i) #1;
        instr_valid_i = 1'b0;
        @(posedge mclk_i) #1;
    endtask

    task automatic t_store;
        logic [31:0] d, a;
        d = pm.gpr_q[17];
        a = pm.gpr_q[4] + 32'h0000_000f;
        op({6'h22, 3'd1, 3'd4, 4'hf}, 1'b0);
        chk({st_req_o, st_half_o, st_byte_en_o}, 6'h21);
        chk(st_addr_o, a);
        chk(st_data_o[7:0], d[7:0]);
        st_exc_i = 1'b1;
        @(posedge mclk_i) #1;
        st_exc_i = 1'b0;
        chk(st_exc_o, 1'b1);
        for (int k = 1; k < 5; k += 3) begin
            d = pm.gpr_q[2];
            a = pm.gpr_q[(k == 1) ? 17 : 4] + 32'h0000_000a;
            op({6'h2a, 3'd2, 3'(k), 4'h5}, 1'b0);
            chk({st_req_o, exc_valid_o, exc_kind_o}, a[0] ? 4'h7 : 4'h8);
            if (!a[0]) begin
                chk({st_half_o, st_byte_en_o}, 5'h13);
                chk(st_addr_o, a);
                chk(st_data_o[15:0], d[15:0]);
            end
        end
    endtask

    task automatic t_regs;
        logic [31:0] a, b;
        a = pm.gpr_q[5];
        b = pm.gpr_q[7] | pm.gpr_q[17];
        op({6'h11, 3'd0, 3'd5, 4'h0}, 1'b0);
        chk({wr_en_a_o, wr_en_b_o, exc_valid_o, wr_addr_a_o}, {3'b100, 5'd16});
        chk(wr_data_a_o, ~a);
        op({6'h11, 3'd1, 3'd7, 4'h9}, 1'b0);
        chk({wr_en_a_o, exc_valid_o, wr_addr_a_o}, {2'b10, 5'd17});
        chk(wr_data_a_o, b);
        a = pm.gpr_q[20];
        b = pm.gpr_q[18];
        op({6'h11, 3'd3, 3'd5, 4'hf}, 1'b0);
        chk({wr_en_a_o, wr_en_b_o, exc_valid_o, wr_addr_a_o, wr_addr_b_o}, {3'b110, 5'd4, 5'd21});
        chk(wr_data_a_o, a);
        chk(wr_data_b_o, b);
        b = pm.gpr_q[16];
        op({6'h11, 3'd0, 3'd4, 4'h4}, 1'b0);
        chk({wr_en_a_o, wr_en_b_o, wr_addr_a_o, wr_addr_b_o}, {2'b11, 5'd5, 5'd6});
        chk(wr_data_a_o, 32'h0000_0000);
        chk(wr_data_b_o, b);
    endtask

    task automatic t_shift;
        logic [31:0] s;
        int n;
        for (int k = 0; k < 16; k++) begin
            s = pm.gpr_q[3];
            n = (k % 8 == 0) ? 8 : k % 8;
            op({(k < 8) ? 6'h09 : 6'h19, 3'd0, 3'd3, 3'(k), 1'b0}, 1'b0);
            chk({wr_en_a_o, exc_valid_o, wr_addr_a_o}, {2'b10, 5'd16});
            chk(wr_data_a_o, (k < 8) ? s << n : s >> n);
        end
    endtask

    task automatic t_brk;
        op({6'h11, 6'h2a, 4'hb}, 1'b0);
        chk({exc_valid_o, exc_kind_o, wr_en_a_o, st_req_o}, 5'h14);
        op({6'h11, 6'h15, 4'hb}, 1'b1);
        chk({exc_valid_o, exc_kind_o, debug_cause_we_o, debug_cause_field_o}, 9'h1a9);
        op({6'h11, 6'h00, 4'h3}, 1'b0);
        chk({wr_en_a_o, wr_en_b_o, st_req_o, exc_valid_o}, 4'h0);
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge mclk_i);
        #1 reset_i = 1'b0;
        t_store;
        t_regs;
        t_shift;
        t_brk;
        wrap_up;
    end

    // About 100 cycles are needed; far beyond that the run has hung
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            err_count++;
            wrap_up;
        end
    end
endmodule
